// File: design/multicast_hash_filter.v
/*
  Receive multicast hash filter of an Ethernet MAC. Samples a 16-bit
  receive word interface, splits words into bytes, hashes the
  destination address of each frame and either delivers the frame to
  the client through a byte buffer or drops it.
  Assumes rx_clk and its data come from another clock domain and are
  much slower than mclk (at least eight mclk cycles per word); the
  filter write port and client_ready come from mclk logic.
*/
`include "mcast_filter_map.vh"
`default_nettype none

module multicast_hash_filter (
  input wire mclk,
  input wire rst,
  input wire rx_clk,
  input wire [1:0] rx_dv,
  input wire [1:0] rx_er,
  input wire [15:0] rx_d,
  input wire filt_we,
  input wire [2:0] filt_index,
  input wire [7:0] filt_value,
  output wire client_valid,
  input wire client_ready,
  output wire [7:0] client_data,
  output wire client_err,
  output wire client_last,
  output reg frame_drop,
  output reg rx_overflow
);

  localparam [1:0] ST_HUNT = 2'h0;
  localparam [1:0] ST_DATA = 2'h1;
  localparam [1:0] ST_FLUSH = 2'h2;

  // ----------------------------------------------------------------
  // Hash CRC over one byte
  // ----------------------------------------------------------------
  // Bit-serial CRC unrolled over a byte, least significant bit first.
  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0] b;
    integer k;
    reg cy;
    reg [31:0] r;
    begin
      r = c;
      for (k = 0; k < 8; k = k + 1)
      begin
        cy = r[31] ^ b[k];
        r = {r[30:0], 1'b0};
        if (cy)
        begin
          r = (r ^ `HASH_POLYNOMIAL) | 32'h00000001;
        end
      end
      crc_byte = r;
    end
  endfunction

  // ----------------------------------------------------------------
  // Link synchronisers and word capture
  // ----------------------------------------------------------------
  reg rxc_s1;
  reg rxc_s2;
  reg rxc_s3;
  reg [19:0] lnk_s1;
  reg [19:0] lnk_s2;
  wire word_en;

  // Every link input passes two flops before anything looks at it.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rxc_s1 <= 1'b0;
      rxc_s2 <= 1'b0;
      rxc_s3 <= 1'b0;
      lnk_s1 <= 20'h00000;
      lnk_s2 <= 20'h00000;
    end
    else
    begin
      rxc_s1 <= rx_clk;
      rxc_s2 <= rxc_s1;
      rxc_s3 <= rxc_s2;
      lnk_s1 <= {rx_er, rx_dv, rx_d};
      lnk_s2 <= lnk_s1;
    end
  end

  // The word is taken at the falling edge of the link clock, half a period
  // away from where the sender changes it, so the synced bits are settled.
  assign word_en = rxc_s3 & ~rxc_s2;

  // ----------------------------------------------------------------
  // Word to byte splitting
  // ----------------------------------------------------------------
  reg [1:0] pend_v_q;
  reg [1:0] pend_e_q;
  reg [15:0] pend_d_q;
  reg end_pend_q;
  reg link_act_q;
  reg ovf_q;
  reg [1:0] st_q;
  wire fifo_in_ready;
  wire take;
  wire [7:0] byte_d;
  wire byte_e;
  wire end_go;

  // A byte is consumed only when the buffer can take a write; a full
  // buffer therefore stalls the splitter until the next word overruns it.
  assign take = (|pend_v_q) & fifo_in_ready & (st_q != ST_FLUSH);
  assign byte_d = pend_v_q[0] ? pend_d_q[7:0] : pend_d_q[15:8];
  assign byte_e = (pend_v_q[0] ? pend_e_q[0] : pend_e_q[1]) | ovf_q;
  assign end_go = end_pend_q & ~(|pend_v_q) & (st_q != ST_FLUSH);

  // Lane 0 is the earlier byte of a word; error bits follow their lane.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pend_v_q <= 2'h0;
      pend_e_q <= 2'h0;
      pend_d_q <= 16'h0000;
      end_pend_q <= 1'b0;
      link_act_q <= 1'b0;
      ovf_q <= 1'b0;
      rx_overflow <= 1'b0;
    end
    else
    begin
      rx_overflow <= 1'b0;
      if (word_en)
      begin
        pend_v_q <= lnk_s2[17:16];
        pend_e_q <= lnk_s2[19:18];
        pend_d_q <= lnk_s2[15:0];
        link_act_q <= |lnk_s2[17:16];
        if (|pend_v_q)
        begin
          ovf_q <= 1'b1;
          rx_overflow <= 1'b1;
        end
        if (link_act_q & ~(|lnk_s2[17:16]))
        begin
          end_pend_q <= 1'b1;
        end
      end
      else if (take)
      begin
        if (pend_v_q[0])
        begin
          pend_v_q[0] <= 1'b0;
        end
        else
        begin
          pend_v_q[1] <= 1'b0;
        end
      end
      if (end_go)
      begin
        end_pend_q <= 1'b0;
        ovf_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Filter table
  // ----------------------------------------------------------------
  localparam [63:0] FILT_RST = `FILT_RESET;
  reg [63:0] filt_q;

  // A write replaces one whole register, so any mix of bits can be set.
  genvar gi;
  generate
    for (gi = 0; gi < `FILT_REGS; gi = gi + 1)
    begin : g_filt
      always @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          filt_q[gi*8+7:gi*8] <= FILT_RST[gi*8+7:gi*8];
        end
        else if (filt_we && (filt_index == gi))
        begin
          filt_q[gi*8+7:gi*8] <= filt_value;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Hash and decision
  // ----------------------------------------------------------------
  reg [31:0] crc_q;
  reg [2:0] dl_cnt_q;
  reg mc_q;
  reg pass_q;
  wire [31:0] crc_nx;
  wire [31:0] crc_sh;
  wire [5:0] hash;
  wire [2:0] reg_sel;
  wire [2:0] bit_sel;
  wire [5:0] bit_m;
  wire mc_nx;
  wire hit;

  assign crc_nx = crc_byte(crc_q, byte_d);
  assign crc_sh = (crc_nx >> `HASH_SHIFT) & `HASH_MASK;
  assign hash = crc_sh[5:0];
  assign reg_sel = hash[5:3];
  assign bit_m = hash & `BIT_SEL_MASK;
  assign bit_sel = bit_m[2:0];
  assign hit = filt_q[{reg_sel, bit_sel}];
  assign mc_nx = (dl_cnt_q == 3'h0) ? byte_d[`MCAST_BIT] : mc_q;

  // ----------------------------------------------------------------
  // Address delay line and frame sequencer
  // ----------------------------------------------------------------
  // The six address bytes wait here until the verdict is known, so that a
  // dropped frame never reaches the buffer.
  reg [53:0] dl_q;
  reg [2:0] fl_cnt_q;
  wire dl_full;
  wire [8:0] oldest;
  wire fifo_wr;
  wire [9:0] fifo_wd;

  assign dl_full = (dl_cnt_q == `DA_BYTES);
  assign oldest = dl_q[53:45];
  assign fifo_wr = pass_q & ((take & (st_q == ST_DATA) & dl_full) |
                             ((st_q == ST_FLUSH) & fifo_in_ready));
  assign fifo_wd = {(st_q == ST_FLUSH) & (fl_cnt_q == 3'h1), oldest};

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= ST_HUNT;
      crc_q <= `CRC_INIT;
      dl_cnt_q <= 3'h0;
      dl_q <= 54'h0;
      fl_cnt_q <= 3'h0;
      mc_q <= 1'b0;
      pass_q <= 1'b0;
      frame_drop <= 1'b0;
    end
    else
    begin
      frame_drop <= 1'b0;
      case (st_q)
        ST_HUNT:
        begin
          // Preamble bytes are discarded until the delimiter shows up.
          if (take && (byte_d == `SFD_BYTE))
          begin
            st_q <= ST_DATA;
            crc_q <= `CRC_INIT;
            dl_cnt_q <= 3'h0;
            pass_q <= 1'b0;
          end
        end
        ST_DATA:
        begin
          if (take)
          begin
            dl_q <= {dl_q[44:0], byte_e, byte_d};
            if (!dl_full)
            begin
              crc_q <= crc_nx;
              mc_q <= mc_nx;
              dl_cnt_q <= dl_cnt_q + 3'h1;
              if (dl_cnt_q == `DA_BYTES - 3'h1)
              begin
                // Unicast passes untouched; multicast needs its bit.
                pass_q <= ~mc_nx | hit;
              end
            end
          end
          else if (end_go)
          begin
            // Runt frames never finish an address and are dropped.
            if (dl_full)
            begin
              st_q <= ST_FLUSH;
              fl_cnt_q <= `DA_BYTES;
              frame_drop <= ~pass_q;
            end
            else
            begin
              st_q <= ST_HUNT;
              frame_drop <= 1'b1;
            end
          end
        end
        ST_FLUSH:
        begin
          // The tail waits for buffer room; the link gap covers this.
          if (fifo_in_ready)
          begin
            dl_q <= {dl_q[44:0], 9'h000};
            fl_cnt_q <= fl_cnt_q - 3'h1;
            if (fl_cnt_q == 3'h1)
            begin
              st_q <= ST_HUNT;
              dl_cnt_q <= 3'h0;
            end
          end
        end
        default:
        begin
          st_q <= ST_HUNT;
        end
      endcase
      if (end_go && (st_q == ST_HUNT))
      begin
        dl_cnt_q <= 3'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Client buffer
  // ----------------------------------------------------------------
  wire [9:0] fifo_rd;

  byte_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(mclk),
    .rst(rst),
    .in_valid(fifo_wr),
    .in_ready(fifo_in_ready),
    .in_data(fifo_wd),
    .out_valid(client_valid),
    .out_ready(client_ready),
    .out_data(fifo_rd)
  );

  assign client_data = fifo_rd[7:0];
  assign client_err = fifo_rd[8];
  assign client_last = fifo_rd[9];

endmodule

`default_nettype wire

// File: design/mcast_filter_map.vh
/*
  Constants of the receive multicast hash filter: frame delimiter,
  hash CRC parameters, filter table shape and client buffer shape.
  Assumes it is included by bare name from the design files only.
*/
`ifndef MCAST_FILTER_MAP_VH
`define MCAST_FILTER_MAP_VH

// ----------------------------------------------------------------
// Frame delimiting
// ----------------------------------------------------------------
`define SFD_BYTE 8'hD5
`define DA_BYTES 3'h6

// ----------------------------------------------------------------
// Hash CRC
// ----------------------------------------------------------------
`define HASH_POLYNOMIAL 32'h04C11DB6
`define CRC_INIT 32'hFFFFFFFF
`define HASH_SHIFT 25
`define HASH_MASK 32'h0000003F
`define REG_SEL_SHIFT 3
`define BIT_SEL_MASK 6'h07
`define MCAST_BIT 0

// ----------------------------------------------------------------
// Filter table and client buffer
// ----------------------------------------------------------------
`define FILT_REGS 8
`define FILT_REG_BITS 8
`define FILT_RESET 64'h0000000000000000
`define FIFO_WIDTH 10
`define FIFO_DEPTH 16
`define FIFO_AW 4

`endif

// File: design/byte_fifo.v
/*
  Small synchronous FIFO with registered read data and valid/ready on
  both sides. Holds the received bytes on their way to the MAC client.
  Assumes one clock and an asynchronous active-high reset.
*/
`default_nettype none

module byte_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);

  localparam [AW:0] FULL_CNT = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  // Full is exact, so the writer really stalls once the drain stops.
  assign in_ready = (count_q != FULL_CNT);
  assign push = in_valid & in_ready;
  assign pop = (count_q != {(AW+1){1'b0}}) & (~out_valid | out_ready);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // The array carries no reset so that it can map onto RAM.
  always @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // ----------------------------------------------------------------
  // Pointers and output register
  // ----------------------------------------------------------------
  // Read data come out of a register, one cycle after the pop.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        out_data <= mem[rd_ptr_q];
        out_valid <= 1'b1;
      end
      else if (out_ready)
      begin
        out_valid <= 1'b0;
      end
      if (push & ~pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (pop & ~push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// File: tb/mhf_link_model.sv
/*
  Link-side model: a free-running word clock and a frame sender that
  puts two bytes on each word but the last of an odd frame, which has
  one. Assumes the bench calls send from one process at a time.
*/
`default_nettype none

module mhf_link_model (
  output logic rx_clk,
  output logic [1:0] rx_dv,
  output logic [1:0] rx_er,
  output logic [15:0] rx_d
);
  timeunit 1ns;
  timeprecision 1ps;

  // Word clock is offset so that its edges never meet the core clock's.
  initial
  begin
    rx_clk = 1'b0;
    rx_dv = 2'h0;
    rx_er = 2'h0;
    rx_d = 16'hA5C3;
    #7;
    forever #160 rx_clk = ~rx_clk;
  end

  // Preamble byte and delimiter, then payload lane 0 first; idle words
  // carry changing data so that a stale value cannot pass.
  task automatic send(input logic [7:0] b[$], input int ep);
    logic [7:0] q[$];
    int k;
    q = b;
    q.push_front(8'hD5);
    q.push_front(8'h55);
    for (k = 0; k < q.size(); k += 2)
    begin
      @(posedge rx_clk);
      rx_dv <= {k + 1 < q.size(), 1'b1};
      rx_er <= {k > 0 && k - 1 == ep, k - 2 == ep};
      rx_d <= {(k + 1 < q.size()) ? q[k + 1] : ~q[k], q[k]};
    end
    repeat (3)
    begin
      @(posedge rx_clk);
      rx_dv <= 2'h0;
      rx_er <= 2'h0;
      rx_d <= ~rx_d;
    end
  endtask
endmodule

`default_nettype wire

// File: tb/multicast_hash_filter_assertions.sv
/*
  Port-level checker for the multicast hash filter.
  Assumes it is bound to the filter's top module.
*/
`default_nettype none

module mhf_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] rx_dv,
  input wire logic [1:0] rx_er,
  input wire logic client_valid,
  input wire logic client_ready,
  input wire logic [7:0] client_data,
  input wire logic client_err,
  input wire logic client_last,
  input wire logic frame_drop,
  input wire logic rx_overflow
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic link_q;
  logic bad_q;

  // Sticky causes: link activity, and lane errors or overflow.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      link_q <= 1'b0;
      bad_q <= 1'b0;
    end
    else
    begin
      link_q <= link_q | (rx_dv != 2'h0);
      bad_q <= bad_q | (rx_er != 2'h0) | rx_overflow;
    end
  end

  chk_reset_quiet: assert property ($past(rst) |-> !client_valid && !frame_drop)
    else $error("output active right after reset");
  chk_drop_pulse: assert property (frame_drop |=> !frame_drop)
    else $error("drop longer than one cycle");
  chk_ovf_pulse: assert property (rx_overflow |=> !rx_overflow)
    else $error("overflow longer than one cycle");
  chk_valid_hold: assert property (client_valid && !client_ready |=> client_valid)
    else $error("valid dropped without ready");
  chk_data_hold: assert property (client_valid && !client_ready |=>
    $stable({client_data, client_err, client_last}))
    else $error("client byte changed while stalled");
  chk_drop_idle: assert property (frame_drop |-> $past(rx_dv, 2) == 2'h0)
    else $error("drop not at frame end");
  chk_err_cause: assert property (client_valid && client_err |-> bad_q)
    else $error("error flag without cause");
  chk_out_cause: assert property ($rose(client_valid) |-> link_q)
    else $error("client byte without link data");
endmodule

bind multicast_hash_filter mhf_checker u_chk (.mclk(mclk), .rst(rst), .rx_dv(rx_dv),
  .rx_er(rx_er), .client_valid(client_valid), .client_ready(client_ready),
  .client_data(client_data), .client_err(client_err), .client_last(client_last),
  .frame_drop(frame_drop), .rx_overflow(rx_overflow));

`default_nettype wire

// File: tb/multicast_hash_filter_tb_top.sv
/*
  Self-checking bench: frames from the link model against a queue model
  of the filter. Assumes the link model and checker are compiled first.
*/
`default_nettype none

module multicast_hash_filter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] bq[$];
  logic mclk, rst, rx_clk, filt_we, client_valid, client_ready, client_err, client_last;
  logic frame_drop, rx_overflow, stall;
  logic [1:0] rx_dv, rx_er;
  logic [15:0] rx_d;
  logic [2:0] filt_index;
  logic [7:0] filt_value, client_data;
  logic [63:0] tbl;
  logic [9:0] got[$];
  bq a, f;
  int n_errors, num_checks, drops, ovfs, h, k;

  multicast_hash_filter uut (.mclk(mclk), .rst(rst), .rx_clk(rx_clk), .rx_dv(rx_dv),
    .rx_er(rx_er), .rx_d(rx_d), .filt_we(filt_we), .filt_index(filt_index),
    .filt_value(filt_value), .client_valid(client_valid), .client_ready(client_ready),
    .client_data(client_data), .client_err(client_err), .client_last(client_last),
    .frame_drop(frame_drop), .rx_overflow(rx_overflow));
  mhf_link_model u_phy (.rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rx_d(rx_d));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Client side stalls at random, or fully while a fill test runs.
  always @(negedge mclk)
    client_ready <= !stall && ($urandom % 4 != 0);

  // Collects accepted bytes and counts event pulses.
  always @(posedge mclk)
  begin
    if (client_valid === 1'b1 && client_ready === 1'b1)
      got.push_back({client_last, client_err, client_data});
    if (frame_drop === 1'b1)
      drops++;
    if (rx_overflow === 1'b1)
      ovfs++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    num_checks++;
    if (seen !== expv)
    begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
      n_errors++;
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hash model: bitwise CRC, LSB first, bits 30 to 25 kept.
  function automatic int hash_of(bq x);
    logic [31:0] c;
    logic cy;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < 6; i++)
      for (int j = 0; j < 8; j++)
      begin
        cy = c[31] ^ x[i][j];
        c = c << 1;
        if (cy)
          c = (c ^ 32'h04C11DB6) | 32'h00000001;
      end
    return (c >> 25) & 32'h0000003F;
  endfunction

  function automatic bq mk(input logic mc);
    bq x;
    repeat (6) x.push_back($urandom);
    x[0][0] = mc;
    return x;
  endfunction

  // Register r bit b is table position r*8+b.
  task automatic wr(input logic [2:0] r, input logic [7:0] v);
    @(negedge mclk);
    filt_we <= 1'b1;
    filt_index <= r;
    filt_value <= v;
    tbl[r * 8 +: 8] = v;
    @(negedge mclk);
    filt_we <= 1'b0;
  endtask

  // Sends one frame and compares delivery or drop with the model.
  task automatic frame(input bq ad, input int len, input int ep);
    bq b;
    int pass, d0, n;
    b = ad;
    while (b.size() > len)
      void'(b.pop_back());
    while (b.size() < len)
      b.push_back($urandom);
    pass = (len >= 6) && (!b[0][0] || tbl[hash_of(b)]);
    d0 = drops;
    got.delete();
    u_phy.send(b, ep);
    n = 0;
    while (n < 300 && (pass ? got.size() < len : drops == d0))
    begin
      @(negedge mclk);
      n++;
    end
    if (n == 300)
    begin
      n_errors++;
      tally_and_finish();
    end
    if (pass)
      for (n = 0; n < len; n++)
        check(got[n], {n == len - 1, n == ep, b[n]});
    else
      check(drops - d0, 1);
    check(got.size(), pass ? len : 0);
  endtask

  initial
  begin
    {rst, stall, filt_we, client_ready} = 4'h8;
    filt_index = 3'h0;
    filt_value = 8'h00;
    tbl = 64'h0000000000000000;
    void'($urandom(35243));
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    check({client_valid, frame_drop, rx_overflow}, 0);
    repeat (4) @(negedge mclk);
    // Empty table: multicast drops, unicast passes with a lane error, and a unicast runt drops.
    a = mk(1'b1);
    frame(a, 20, -1);
    a[0][0] = 1'b0;
    frame(a, 17, 3);
    frame(a, 4, -1);
    $display("test basic done");
    // Bits accumulate; the first address still passes after all six are set.
    f = mk(1'b1);
    for (k = 0; k < 6; k++)
    begin
      a = (k == 0) ? f : mk(1'b1);
      h = hash_of(a);
      wr(h >> 3, tbl[(h >> 3) * 8 +: 8] | (8'h01 << (h & 7)));
      frame(a, 12, -1);
      frame(mk(1'b1), 12, -1);
    end
    frame(f, 9, -1);
    $display("test hash done");
    for (k = 0; k < 8; k++)
      wr(k, 8'hFF);
    repeat (4) frame(mk(1'b1), 14, -1);
    $display("test all ones done");
    // Full stall fills the buffer until it refuses, then drain to empty.
    stall = 1'b1;
    a = mk(1'b0);
    repeat (34) a.push_back($urandom);
    u_phy.send(a, -1);
    check(ovfs > 0, 1);
    stall = 1'b0;
    for (k = 0; k < 200 && client_valid !== 1'b0; k++)
      @(negedge mclk);
    check(client_valid, 0);
    frame(mk(1'b0), 10, -1);
    $display("test fill done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
